/* File: verilog/spb_serial.sv */
`timescale 1ns/10ps
`default_nettype none
`include "spb_defines.svh"
module spb_serial (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Baud source and timer 2 pins
  input wire logic timer1_ovf,
  input wire logic timer2_count_pin,
  input wire logic timer2_ext_pin,
  // Serial pins
  input wire logic port_pin_a_in,
  output logic port_pin_a_out,
  output logic port_pin_a_oe,
  output logic port_pin_b_out,
  // Interrupt requests
  output logic serial_irq,
  output logic timer2_irq
);
  spb_pkg::spb_tx_e tx_st;
  spb_pkg::spb_rx_e rx_st;
  logic [3:0] ph;
  logic [3:0] next_ph;
  logic mc_tick;
  logic s1p1;
  logic mode1;
  logic rx_en;
  logic mpf;
  logic rx_done;
  logic tx_done;
  logic rx_ninth;
  logic [7:0] rx_buf;
  logic [8:0] tx_sr;
  logic tx_data;
  logic [7:0] rx_sr;
  logic [8:0] rx_sr9;
  logic rx_first;
  logic rx_pin_q;
  logic pin_s5;
  logic smp_a;
  logic smp_b;
  logic maj;
  logic [3:0] tx_div;
  logic [3:0] rx_div;
  logic t2_run;
  logic t2_csrc;
  logic t2_exten;
  logic tx_sel;
  logic rx_sel;
  logic ext_flag;
  logic ovf_flag;
  logic [15:0] t2_count;
  logic [15:0] t2_reload;
  logic t2_tick;
  logic t2_ovf_set;
  logic t2_ext_set;
  logic tx_tick;
  logic rx_tick;
  logic tx_roll;
  logic wr_sc;
  logic wr_buf;
  logic wr_t2;
  logic tx_fin;
  logic rx_start1;
  logic rx0_final;
  logic rx1_final;
  logic rx1_keep;
  logic rx_set;
  logic shclk_lvl;
  logic m0_active;

  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction

  assign wr_sc = wr && addr == `SPB_A_SCTRL;
  assign wr_buf = wr && addr == `SPB_A_SERBUF; // [R23]
  assign wr_t2 = wr && addr == `SPB_A_T2CTRL;

  // Twelve oscillator phases form one machine cycle, S1P1 first
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ph <= `SPB_PH_S1P1;
    end else begin
      ph <= next_ph;
    end
  end
  assign mc_tick = ph == `SPB_PH_S6P2;
  assign s1p1 = ph == `SPB_PH_S1P1;
  assign next_ph = mc_tick ? `SPB_PH_S1P1 : ph + 4'h1;

  spb_timer2 u_timer2 (
    .clk(clk),
    .sys_rst(sys_rst),
    .state_tick(ph[0]),
    .mc_tick(mc_tick),
    .run(t2_run),
    .count_src(t2_csrc),
    .baud_mode(tx_sel | rx_sel), // [R01]
    .ext_en(t2_exten),
    .count_pin(timer2_count_pin),
    .ext_pin(timer2_ext_pin),
    .wr_lo(wr && addr == `SPB_A_T2LO),
    .wr_hi(wr && addr == `SPB_A_T2HI),
    .wr_rl_lo(wr && addr == `SPB_A_RLLO),
    .wr_rl_hi(wr && addr == `SPB_A_RLHI),
    .wdata(wdata),
    .count(t2_count),
    .reload(t2_reload),
    .ovf_tick(t2_tick),
    .ovf_set(t2_ovf_set),
    .ext_set(t2_ext_set)
  );

  // Each direction picks its 16x clock on its own
  assign tx_tick = tx_sel ? t2_tick : timer1_ovf; // [R25] [R01]
  assign rx_tick = rx_sel ? t2_tick : timer1_ovf; // [R25]

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_div <= 4'h0;
    end else if (tx_tick) begin
      tx_div <= tx_div + 4'h1;
    end
  end
  assign tx_roll = tx_tick && tx_div == `SPB_DIV_LAST; // [R03] [R05]

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_div <= 4'h0;
    end else if (rx_start1) begin
      rx_div <= 4'h0; // [R20]
    end else if (rx_tick) begin
      rx_div <= rx_div + 4'h1;
    end
  end

  // Control bits written by software
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode1 <= 1'b0;
      rx_en <= 1'b0;
      mpf <= 1'b0;
      t2_run <= 1'b0;
      t2_csrc <= 1'b0;
      t2_exten <= 1'b0;
      tx_sel <= 1'b0;
      rx_sel <= 1'b0;
    end else begin
      if (wr_sc) begin
        mode1 <= wdata[`SPB_SC_MODE1];
        rx_en <= wdata[`SPB_SC_RXEN];
        mpf <= wdata[`SPB_SC_MPF];
      end
      if (wr_t2) begin
        t2_run <= wdata[`SPB_T2_RUN];
        t2_csrc <= wdata[`SPB_T2_CSRC];
        t2_exten <= wdata[`SPB_T2_EXTEN];
        tx_sel <= wdata[`SPB_T2_TXSEL];
        rx_sel <= wdata[`SPB_T2_RXSEL];
      end
    end
  end

  // Event flags: a hardware set wins over a software write
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_done <= 1'b0;
      tx_done <= 1'b0;
      ext_flag <= 1'b0;
      ovf_flag <= 1'b0;
    end else begin
      if (wr_sc) begin
        rx_done <= wdata[`SPB_SC_RXDONE];
        tx_done <= wdata[`SPB_SC_TXDONE];
      end
      if (wr_t2) begin
        ext_flag <= wdata[`SPB_T2_EXTF];
        ovf_flag <= wdata[`SPB_T2_OVFF];
      end
      if (rx_set) begin
        rx_done <= 1'b1;
      end
      if (tx_fin) begin
        tx_done <= 1'b1; // [R12] [R19]
      end
      if (t2_ext_set) begin
        ext_flag <= 1'b1; // [R07]
      end
      if (t2_ovf_set) begin
        ovf_flag <= 1'b1; // [R06]
      end
    end
  end

  assign tx_fin = (!mode1 && tx_st == spb_pkg::tx_last && s1p1) ||
                  (mode1 && tx_st == spb_pkg::tx_send && tx_roll && tx_data &&
                   tx_sr[8:1] == `SPB_TX_MARK);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_st <= spb_pkg::tx_idle;
      tx_sr <= 9'h000;
      tx_data <= 1'b0;
    end else begin
      case (tx_st)
        spb_pkg::tx_idle: begin
          if (wr_buf) begin
            tx_sr <= {1'b1, wdata}; // [R10] [R17]
            tx_st <= spb_pkg::tx_req;
          end
        end
        spb_pkg::tx_req: begin
          if (!mode1 && mc_tick) begin
            tx_st <= spb_pkg::tx_send; // [R10]
          end else if (mode1 && tx_roll) begin
            tx_st <= spb_pkg::tx_arm; // [R17]
          end
        end
        spb_pkg::tx_arm: begin
          if (s1p1) begin
            tx_st <= spb_pkg::tx_send; // [R17] [R18]
            tx_data <= 1'b0;
          end
        end
        spb_pkg::tx_send: begin
          if (!mode1 && mc_tick) begin
            tx_sr <= {1'b0, tx_sr[8:1]}; // [R11] [R09]
            if (tx_sr[8:1] == `SPB_TX_MARK) begin
              tx_st <= spb_pkg::tx_last; // [R12]
            end
          end else if (mode1 && tx_roll) begin
            if (!tx_data) begin
              tx_data <= 1'b1; // [R18]
            end else begin
              tx_sr <= {1'b0, tx_sr[8:1]}; // [R18] [R16]
              if (tx_sr[8:1] == `SPB_TX_MARK) begin
                tx_st <= spb_pkg::tx_idle; // [R19]
              end
            end
          end
        end
        spb_pkg::tx_last: begin
          if (s1p1) begin
            tx_st <= spb_pkg::tx_idle; // [R12]
          end
        end
        default: tx_st <= spb_pkg::tx_idle;
      endcase
    end
  end

  // Receive sampling
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_pin_q <= 1'b1;
      pin_s5 <= 1'b1;
      smp_a <= 1'b1;
      smp_b <= 1'b1;
    end else begin
      if (rx_tick) begin
        rx_pin_q <= port_pin_a_in;
      end
      if (ph == `SPB_PH_S5P2) begin
        pin_s5 <= port_pin_a_in; // [R14]
      end
      if (rx_tick && rx_div == `SPB_SMP_A) begin
        smp_a <= port_pin_a_in; // [R21]
      end
      if (rx_tick && rx_div == `SPB_SMP_B) begin
        smp_b <= port_pin_a_in;
      end
    end
  end
  assign maj = maj3(smp_a, smp_b, port_pin_a_in); // [R21]

  assign rx_start1 = mode1 && rx_st == spb_pkg::rx_idle && rx_en && rx_tick &&
                     rx_pin_q && !port_pin_a_in; // [R20]
  assign rx0_final = rx_st == spb_pkg::rx_shift0 && mc_tick && !rx_sr[0];
  assign rx1_final = rx_st == spb_pkg::rx_frame && rx_tick && rx_div == `SPB_SMP_C &&
                     !rx_first && !rx_sr9[0];
  assign rx1_keep = rx1_final && !rx_done && (!mpf || maj); // [R22]
  assign rx_set = (rx_st == spb_pkg::rx_last0 && s1p1) || rx1_keep; // [R15] [R22]

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_st <= spb_pkg::rx_idle;
      rx_sr <= 8'h00;
      rx_sr9 <= 9'h000;
      rx_first <= 1'b0;
    end else begin
      case (rx_st)
        spb_pkg::rx_idle: begin
          if (!mode1 && rx_en && !rx_done) begin
            rx_st <= spb_pkg::rx_arm; // [R13]
          end else if (rx_start1) begin
            rx_sr9 <= `SPB_RX1_INIT; // [R20]
            rx_first <= 1'b1;
            rx_st <= spb_pkg::rx_frame;
          end
        end
        spb_pkg::rx_arm: begin
          if (mc_tick) begin
            rx_sr <= `SPB_RX0_INIT; // [R13]
            rx_st <= spb_pkg::rx_shift0;
          end
        end
        spb_pkg::rx_shift0: begin
          if (mc_tick) begin
            rx_sr <= {pin_s5, rx_sr[7:1]}; // [R14] [R09]
            if (!rx_sr[0]) begin
              rx_st <= spb_pkg::rx_last0; // [R15]
            end
          end
        end
        spb_pkg::rx_last0: begin
          if (s1p1) begin
            rx_st <= spb_pkg::rx_idle; // [R15]
          end
        end
        spb_pkg::rx_frame: begin
          if (rx_tick && rx_div == `SPB_SMP_C) begin
            rx_sr9 <= {maj, rx_sr9[8:1]}; // [R16]
            rx_first <= 1'b0;
            if (rx_first && maj) begin
              rx_st <= spb_pkg::rx_idle; // [R21]
            end else if (rx1_final) begin
              rx_st <= spb_pkg::rx_idle; // [R22]
            end
          end
        end
        default: rx_st <= spb_pkg::rx_idle;
      endcase
    end
  end

  // Receive buffer stays apart from the transmit register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_buf <= 8'h00;
      rx_ninth <= 1'b0;
    end else if (rx0_final) begin
      rx_buf <= {pin_s5, rx_sr[7:1]}; // [R15]
    end else if (rx1_keep) begin
      rx_buf <= rx_sr9[8:1]; // [R22] [R23]
      rx_ninth <= maj; // [R16]
    end
  end

  // Pin drivers, aligned with the phase that follows the edge
  assign m0_active = !mode1 && (tx_st == spb_pkg::tx_send || tx_st == spb_pkg::tx_last ||
                     rx_st == spb_pkg::rx_shift0 || rx_st == spb_pkg::rx_last0);
  assign shclk_lvl = !(next_ph >= `SPB_PH_S3P1 && next_ph <= `SPB_PH_S5P2);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      port_pin_a_out <= 1'b1;
      port_pin_a_oe <= 1'b0;
      port_pin_b_out <= 1'b1;
    end else begin
      port_pin_a_out <= tx_sr[0];
      port_pin_a_oe <= !mode1 && (tx_st == spb_pkg::tx_send || tx_st == spb_pkg::tx_last);
      if (mode1) begin
        port_pin_b_out <= (tx_st == spb_pkg::tx_send) ? (tx_data & tx_sr[0]) : 1'b1; // [R18]
      end else begin
        port_pin_b_out <= m0_active ? shclk_lvl : 1'b1; // [R11] [R14]
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      serial_irq <= 1'b0;
      timer2_irq <= 1'b0;
    end else begin
      serial_irq <= rx_done | tx_done; // [R24]
      timer2_irq <= ext_flag | ovf_flag;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        `SPB_A_SCTRL: rdata <= {rx_st != spb_pkg::rx_idle, mode1, mpf, rx_en,
                                tx_st != spb_pkg::tx_idle, rx_ninth, tx_done, rx_done};
        `SPB_A_SERBUF: rdata <= rx_buf; // [R23]
        `SPB_A_T2CTRL: rdata <= {1'b0, ovf_flag, ext_flag, rx_sel, tx_sel,
                                 t2_exten, t2_run, t2_csrc};
        `SPB_A_T2LO: rdata <= t2_count[7:0];
        `SPB_A_T2HI: rdata <= t2_count[15:8];
        `SPB_A_RLLO: rdata <= t2_reload[7:0];
        `SPB_A_RLHI: rdata <= t2_reload[15:8];
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence tx1_begin;
    mode1 && tx_st == spb_pkg::tx_arm && s1p1;
  endsequence

  chk_tx0_send_delay: assert property ( // [R10]
    (wr_buf && tx_st == spb_pkg::tx_idle && !mode1) |-> ##[2:13] (tx_st == spb_pkg::tx_send))
    else $error("mode 0 transmit did not go active in time");
  chk_shift_clk_low: assert property ( // [R11]
    (!mode1 && tx_st == spb_pkg::tx_send && $past(tx_st) == spb_pkg::tx_send &&
     ph == 4'h6) |-> !port_pin_b_out)
    else $error("shift clock high during S4");
  chk_tx0_finish: assert property ( // [R12]
    (!mode1 && tx_st == spb_pkg::tx_last && s1p1) |=> (tx_done && tx_st == spb_pkg::tx_idle))
    else $error("mode 0 transmit did not finish at S1P1");
  chk_rx0_load: assert property ( // [R13]
    (rx_st == spb_pkg::rx_arm && mc_tick) |=> (rx_sr == `SPB_RX0_INIT && ph == 4'h0))
    else $error("mode 0 receive register not preset");
  chk_rx1_start: assert property ( // [R20]
    rx_start1 |=> (rx_div == 4'h0 && rx_sr9 == `SPB_RX1_INIT))
    else $error("start edge did not reset divider");
  chk_false_start: assert property ( // [R21]
    (rx_st == spb_pkg::rx_frame && rx_first && rx_tick && rx_div == 4'h9 && maj)
    |=> rx_st == spb_pkg::rx_idle)
    else $error("false start bit not rejected");
  chk_rx1_discard: assert property ( // [R22]
    (rx1_final && rx_done) |=> (rx_buf == $past(rx_buf) && rx_st == spb_pkg::rx_idle))
    else $error("frame kept while receive done was set");
  chk_irq_or: assert property ( // [R24]
    (rx_done || tx_done) |=> serial_irq)
    else $error("serial interrupt missing");
  chk_buf_read: assert property ( // [R23]
    (rd && addr == `SPB_A_SERBUF) |=> (rdata == $past(rx_buf)))
    else $error("buffer read did not return receive register");
  chk_tx1_start_bit: assert property ( // [R18]
    tx1_begin |=> (tx_st == spb_pkg::tx_send) ##1 !port_pin_b_out)
    else $error("start bit not driven");
  chk_baud_no_ovf: assert property ( // [R06]
    (tx_sel || rx_sel) && !wr_t2 |=> !$rose(ovf_flag))
    else $error("overflow flag set in baud mode");
endmodule
`default_nettype wire

/* File: verilog/spb_defines.svh */
`ifndef SPB_DEFINES_SVH
`define SPB_DEFINES_SVH
// How it works
// R01 - Either clock select bit puts timer 2 into baud mode; directions pick sources apart.
// R02 - Baud mode: each timer 2 rollover reloads all 16 bits from the reload bytes.
// R03 - Timer 2 sourced bit rate is its overflow rate divided by sixteen.
// R04 - Baud mode timer function counts every state time, not every machine cycle.
// R05 - Internal baud rate is oscillator over 32 times (65536 minus reload).
// R06 - Baud mode rollover never sets the timer 2 overflow flag or its interrupt.
// R07 - Baud mode external falling edge sets the event flag but never reloads.
// R08 - Software stops timer 2 before touching counter or reload bytes in baud mode.
// R09 - Mode 0 moves eight bits LSB first, shift clock at oscillator over twelve.
// R10 - Mode 0 buffer write loads marker one; transmit goes active one cycle later.
// R11 - Mode 0 shift clock low S3 to S5, high otherwise; shift at S6P2.
// R12 - Mode 0 transmit: marker beside MSB gives last shift, then done at S1P1.
// R13 - Mode 0 receive starts on enable with done clear, loading all ones but one.
// R14 - Mode 0 receive shift clock toggles S3P1, S6P1; data taken at S5P2.
// R15 - Mode 0 receive: marker zero at end gives last shift, buffer, done at S1P1.
// R16 - Mode 1 frame is start zero, eight data bits LSB first, stop one.
// R17 - Mode 1 write loads stop marker; start waits for divide-by-16 rollover then S1P1.
// R18 - Mode 1: start bit first, data one bit later, first shift one more later.
// R19 - Mode 1 transmit: marker beside MSB gives last shift, drop active, set done.
// R20 - Mode 1 receive samples at 16x; falling edge resets divider, loads all ones.
// R21 - Bits are majority of states 7, 8, 9; bad start bit restarts the hunt.
// R22 - Frame kept only if done clear and filter off or stop one; hunt resumes.
// R23 - Buffer write loads transmit register; buffer read returns separate receive register.
// R24 - Serial interrupt is OR of receive done and transmit done; no auto clear.
// R25 - Transmit and receive each take their 16x clock from timer 1 or timer 2.
`define SPB_A_SCTRL 3'h0
`define SPB_A_SERBUF 3'h1
`define SPB_A_T2CTRL 3'h2
`define SPB_A_T2LO 3'h3
`define SPB_A_T2HI 3'h4
`define SPB_A_RLLO 3'h5
`define SPB_A_RLHI 3'h6
`define SPB_SC_RXDONE 0
`define SPB_SC_TXDONE 1
`define SPB_SC_NINTH 2
`define SPB_SC_TXBUSY 3
`define SPB_SC_RXEN 4
`define SPB_SC_MPF 5
`define SPB_SC_MODE1 6
`define SPB_SC_RXBUSY 7
`define SPB_T2_CSRC 0
`define SPB_T2_RUN 1
`define SPB_T2_EXTEN 2
`define SPB_T2_TXSEL 3
`define SPB_T2_RXSEL 4
`define SPB_T2_EXTF 5
`define SPB_T2_OVFF 6
`define SPB_PH_S1P1 4'h0
`define SPB_PH_S3P1 4'h4
`define SPB_PH_S5P2 4'h9
`define SPB_PH_S6P2 4'hb
`define SPB_DIV_LAST 4'hf
`define SPB_SMP_A 4'h7
`define SPB_SMP_B 4'h8
`define SPB_SMP_C 4'h9
`define SPB_TX_MARK 8'h01
`define SPB_RX0_INIT 8'h7f
`define SPB_RX1_INIT 9'h1ff
`define SPB_T2_MAX 16'hffff
`endif

/* File: verilog/spb_pkg.sv */
`default_nettype none
package spb_pkg;
  typedef enum logic [2:0] {tx_idle, tx_req, tx_arm, tx_send, tx_last} spb_tx_e;
  typedef enum logic [2:0] {rx_idle, rx_arm, rx_shift0, rx_last0, rx_frame} spb_rx_e;
endpackage
`default_nettype wire

/* File: verilog/spb_timer2.sv */
`timescale 1ns/10ps
`default_nettype none
`include "spb_defines.svh"
module spb_timer2 (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Timing and control
  input wire logic state_tick,
  input wire logic mc_tick,
  input wire logic run,
  input wire logic count_src,
  input wire logic baud_mode,
  input wire logic ext_en,
  input wire logic count_pin,
  input wire logic ext_pin,
  // Byte writes
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic wr_rl_lo,
  input wire logic wr_rl_hi,
  input wire logic [7:0] wdata,
  // Results
  output logic [15:0] count,
  output logic [15:0] reload,
  output logic ovf_tick,
  output logic ovf_set,
  output logic ext_set
);
  logic count_pin_q;
  logic ext_pin_q;
  logic cnt_en;
  logic roll;
  logic any_wr;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_pin_q <= 1'b1;
      ext_pin_q <= 1'b1;
    end else begin
      count_pin_q <= count_pin;
      ext_pin_q <= ext_pin;
    end
  end

  assign cnt_en = run & (count_src ? (count_pin_q & ~count_pin) :
                         (baud_mode ? state_tick : mc_tick)); // [R04]
  assign roll = cnt_en & (count == `SPB_T2_MAX);
  assign ext_set = ext_en & ext_pin_q & ~ext_pin; // [R07]
  assign ovf_tick = roll;
  assign ovf_set = roll & ~baud_mode; // [R06]
  assign any_wr = wr_lo | wr_hi | wr_rl_lo | wr_rl_hi;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= 16'h0000;
    end else begin
      if (roll || (ext_set && !baud_mode)) begin
        count <= reload; // [R02] [R07]
      end else if (cnt_en) begin
        count <= count + 16'h0001;
      end
      if (wr_lo) begin
        count[7:0] <= wdata;
      end
      if (wr_hi) begin
        count[15:8] <= wdata;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reload <= 16'h0000;
    end else begin
      if (wr_rl_lo) begin
        reload[7:0] <= wdata;
      end
      if (wr_rl_hi) begin
        reload[15:8] <= wdata;
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_baud_reload: assert property ( // [R02]
    (roll && !any_wr) |=> (count == $past(reload)))
    else $error("timer 2 did not reload on rollover");
  chk_ext_no_reload: assert property ( // [R07]
    (ext_set && baud_mode && !roll && !any_wr) |=>
    (count == $past(count) + 16'($past(cnt_en))))
    else $error("external edge reloaded timer 2 in baud mode");
  chk_state_rate: assert property ( // [R04]
    (run && baud_mode && !count_src && !any_wr && count != `SPB_T2_MAX
     && state_tick) |=> (count == $past(count) + 16'h0001))
    else $error("baud mode timer missed a state time");
endmodule
`default_nettype wire

/* File: verification/spb_remote.sv */
`timescale 1ns/10ps
`default_nettype none
module spb_remote #(
  parameter int BIT_CLK = 64
) (
  // Clock and mode
  input wire logic clk,
  input wire logic mode1,
  // Port pins
  input wire logic port_pin_a_out,
  input wire logic port_pin_a_oe,
  input wire logic port_pin_b_out,
  output logic port_pin_a_in,
  // Captured frame
  output logic frame_valid,
  output logic [9:0] frame
);
  logic [7:0] sh0;
  logic [7:0] sh1;
  int n0;
  initial begin
    port_pin_a_in = 1'b1;
    sh1 = 8'hff;
    frame_valid = 1'b0;
    frame = 10'h000;
    sh0 = 8'h00;
    n0 = 0;
  end
  // Frame sampled mid-bit: start, eight data LSB first, stop
  always begin
    @(negedge port_pin_b_out iff mode1);
    repeat (BIT_CLK / 2) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      frame[i] <= port_pin_b_out;
      if (i < 9) repeat (BIT_CLK) @(posedge clk);
    end
    frame_valid <= 1'b1;
    @(posedge clk);
    frame_valid <= 1'b0;
  end
  // Shift register partner takes data on the rising shift clock
  always @(posedge port_pin_b_out) begin
    if (!mode1 && port_pin_a_oe) begin
      sh0 = {port_pin_a_out, sh0[7:1]};
      n0 = n0 + 1;
      if (n0 == 8) begin
        frame <= {1'b1, sh0, 1'b0};
        frame_valid <= 1'b1;
        @(posedge clk);
        frame_valid <= 1'b0;
      end
    end
  end
  always @(negedge port_pin_a_oe) n0 = 0;
  // Shift register partner presents its next bit on each falling shift clock
  always @(negedge port_pin_b_out) begin
    if (!mode1 && !port_pin_a_oe) begin
      port_pin_a_in <= sh1[0];
      sh1 = {1'b1, sh1[7:1]};
    end
  end
  task automatic load0(input logic [7:0] v);
    sh1 = v;
  endtask
  // Line returns high after each frame, as if pulled up
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      port_pin_a_in <= f[i];
      repeat (BIT_CLK - 1) @(posedge clk);
    end
    @(posedge clk);
    port_pin_a_in <= 1'b1;
  endtask
  // Short low pulse that must not pass as a start bit
  task automatic glitch();
    @(posedge clk);
    port_pin_a_in <= 1'b0;
    repeat (5) @(posedge clk);
    port_pin_a_in <= 1'b1;
    repeat (200) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* File: verification/serial_port_sync_async_baudgen_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "spb_defines.svh"
module serial_port_sync_async_baudgen_bench;
  logic clk, sys_rst, wr, rd, rd_q, timer1_ovf, ext_pin, mode1, line_a;
  logic pin_a_in, pin_a_out, pin_a_oe, pin_b_out, serial_irq, timer2_irq, fv;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, b;
  logic [9:0] frame;
  logic [7:0] rd_exp[$];
  logic [9:0] ser_q[$];
  int fail_count, n_tests;
  logic [1:0] t1_cnt = 2'h0;
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Pin a carries the device's data while it drives, else the remote line
  assign pin_a_in = pin_a_oe ? pin_a_out : line_a;
  spb_serial i_spb_serial (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .timer1_ovf(timer1_ovf), .timer2_count_pin(1'b1),
    .timer2_ext_pin(ext_pin), .port_pin_a_in(pin_a_in), .port_pin_a_out(pin_a_out),
    .port_pin_a_oe(pin_a_oe), .port_pin_b_out(pin_b_out), .serial_irq(serial_irq),
    .timer2_irq(timer2_irq));
  spb_remote #(.BIT_CLK(64)) i_spb_remote (.clk(clk), .mode1(mode1),
    .port_pin_a_out(pin_a_out), .port_pin_a_oe(pin_a_oe), .port_pin_b_out(pin_b_out),
    .port_pin_a_in(line_a), .frame_valid(fv), .frame(frame));
  task automatic test_done();
    if (rd_exp.size() != 0 || ser_q.size() != 0) fail_count++;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp_rd(input logic [7:0] e);
    n_tests++;
    if (rdata !== e) begin
      fail_count++;
      $display("[ERR] %0t read %h exp %h", $time, rdata, e);
    end
  endtask
  task automatic cmp_ser(input logic [9:0] e);
    n_tests++;
    if (frame !== e) begin
      fail_count++;
      $display("[ERR] %0t frame %h exp %h", $time, frame, e);
    end
  endtask
  task automatic cmp_bit(input logic v, input logic e);
    n_tests++;
    if (v !== e) begin
      fail_count++;
      $display("[ERR] %0t flag %b exp %b", $time, v, e);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    rd_exp.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic wait_ser();
    for (int i = 0; i < 2000 && ser_q.size() != 0; i++) @(posedge clk);
    if (ser_q.size() != 0) begin
      fail_count++;
      $display("[ERR] %0t no frame", $time);
      test_done();
    end
  endtask
  task automatic tx_byte(input logic [7:0] exp_ctrl);
    b = 8'($urandom);
    ser_q.push_back({1'b1, b, 1'b0});
    wr_reg(`SPB_A_SERBUF, b);
    wait_ser();
    // Done flag follows the last shift clock edge by a few cycles
    repeat (16) @(posedge clk);
    rd_reg(`SPB_A_SCTRL, exp_ctrl);
    cmp_bit(serial_irq, 1'b1);
  endtask
  always @(posedge clk) begin
    rd_q <= rd;
    // Timer 1 tick every fourth cycle gives the same 64-cycle bit as timer 2
    t1_cnt <= t1_cnt + 2'h1;
    timer1_ovf <= (t1_cnt == 2'h0);
    if (rd_q) cmp_rd(rd_exp.pop_front());
    if (fv) cmp_ser(ser_q.pop_front());
  end
  initial begin
    sys_rst = 1'b1;
    {wr, rd, addr, wdata} = '0;
    {ext_pin, mode1} = 2'b11;
    fail_count = 0;
    n_tests = 0;
    void'($urandom(32'h095761af));
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 8; a++) rd_reg(a[2:0], 8'h00);
    // Counter and reload set to fffe while stopped
    for (int a = 3; a < 7; a++) wr_reg(a[2:0], a[0] ? 8'hfe : 8'hff);
    wr_reg(3'h7, 8'hff);
    rd_reg(3'h7, 8'h00);
    rd_reg(`SPB_A_RLHI, 8'hff);
    wr_reg(`SPB_A_T2CTRL, 8'h1e);
    wr_reg(`SPB_A_SCTRL, 8'h50);
    @(posedge clk) ext_pin <= 1'b0;
    repeat (4) @(posedge clk);
    ext_pin <= 1'b1;
    repeat (200) @(posedge clk);
    rd_reg(`SPB_A_T2CTRL, 8'h3e);
    cmp_bit(timer2_irq, 1'b1);
    wr_reg(`SPB_A_T2CTRL, 8'h1e);
    repeat (100) @(posedge clk);
    cmp_bit(timer2_irq, 1'b0);
    for (int k = 0; k < 3; k++) begin
      tx_byte(8'h52);
      wr_reg(`SPB_A_SCTRL, 8'h50);
    end
    // Receive takes its 16x clock from timer 1, transmit stays on timer 2
    wr_reg(`SPB_A_T2CTRL, 8'h0e);
    b = 8'($urandom);
    i_spb_remote.send(b, 1'b1);
    rd_reg(`SPB_A_SCTRL, 8'h55);
    rd_reg(`SPB_A_SERBUF, b);
    i_spb_remote.send(~b, 1'b1);
    rd_reg(`SPB_A_SERBUF, b);
    wr_reg(`SPB_A_SCTRL, 8'h70);
    i_spb_remote.glitch();
    i_spb_remote.send(~b, 1'b0);
    rd_reg(`SPB_A_SCTRL, 8'h74);
    i_spb_remote.send(b ^ 8'h5a, 1'b1);
    rd_reg(`SPB_A_SERBUF, b ^ 8'h5a);
    mode1 <= 1'b0;
    wr_reg(`SPB_A_SCTRL, 8'h00);
    tx_byte(8'h06);
    b = 8'($urandom);
    i_spb_remote.load0(b);
    wr_reg(`SPB_A_SCTRL, 8'h10);
    repeat (150) @(posedge clk);
    rd_reg(`SPB_A_SCTRL, 8'h15);
    rd_reg(`SPB_A_SERBUF, b);
    cmp_bit(serial_irq, 1'b1);
    repeat (4) @(posedge clk);
    test_done();
  end
endmodule
`default_nettype wire
